// File: dv/cpu_bus_model.sv
// cpu side bus master: one access at a time, gives up if unanswered
// assumes ack is a one-cycle pulse with rdata valid beside it
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output logic             req,
  output logic [23:0]      addr,
  output logic             write,
  output logic [1:0]       size,
  output logic             program_space,
  output logic [31:0]      wdata
);
  initial {req, addr, write, size, program_space, wdata} = '0;
  task automatic access(input logic [23:0] a, input logic w, input logic [1:0] s,
                        input logic p, input logic [31:0] d, input int gap,
                        output logic hit, output logic [31:0] q);
    int i;
    hit = 1'b0;
    q = 32'h0;
    repeat (gap + 1) @(negedge sys_clk);
    {req, addr, write, size, program_space, wdata} = {1'b1, a, w, s, p, d};
    // bus monitor: ten cycles without ack ends the cycle
    for (i = 0; i < 10 && !hit; i++) begin
      @(negedge sys_clk);
      if (ack === 1'b1) begin
        hit = 1'b1;
        q = rdata;
      end
    end
    // released lines show the inverse so stale values never pass
    {req, addr, write, size, program_space, wdata} = {1'b0, ~a, ~w, ~s, ~p, ~d};
  endtask
endmodule

// File: dv/sram_chk.sv
// port checker for the standby ram module, bound from the bench
// assumes one master that drops req in the cycle ack is high
`timescale 1ns/1ps
module sram_chk
  import sram_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        standby_supply_input,
  input wire logic        req,
  input wire logic [23:0] addr,
  input wire logic        write,
  input wire logic [1:0]  size,
  input wire logic        program_space,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        module_stopped,
  input wire logic        base_locked
);
  logic [3:0] held;
  wire two  = size == SIZE_LONG || (size == SIZE_WORD && addr[0]);
  wire arr  = req && addr[23:3] != REG_BLOCK_BASE[23:3];
  wire bytr = req && !write && size == SIZE_BYTE;
  wire cfgw = req && write && addr == REG_BLOCK_BASE;
  wire lckw = cfgw && wdata[LOCK_BIT];
  // request cycles so far; the master releases req once ack shows
  always_ff @(posedge sys_clk) begin
    held <= (req && !ack) ? held + 4'h1 : 4'h0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_one; ack && !$past(two); endsequence
  sequence s_two; ack && $past(two); endsequence
  a_one_part: assert property (s_one |-> held == 4'(BUS_CYCLE_CLKS + 1))
    else $error("one-part access length wrong");
  a_two_part: assert property (s_two |-> held == 4'(2 * BUS_CYCLE_CLKS + 1))
    else $error("two-part access length wrong");
  a_reset_state: assert property ($fell(reset) |=> module_stopped && !base_locked)
    else $error("state after reset wrong");
  a_lock_sticky: assert property (base_locked |=> base_locked)
    else $error("lock cleared without reset");
  a_lock_source: assert property ($rose(base_locked) |-> $past(lckw) || $past(lckw, 2))
    else $error("lock set without config write");
  a_stop_source: assert property ($fell(module_stopped) |-> $past(cfgw) || $past(cfgw, 2))
    else $error("stop cleared without config write");
  a_stopped_quiet: assert property (module_stopped && $past(arr) |-> !ack)
    else $error("array answered while stopped");
  a_standby_quiet: assert property (standby_supply_input [*8] ##0 $past(arr) |-> !ack)
    else $error("array answered on standby");
  a_byte_lanes: assert property (ack && $past(bytr) |-> rdata[31:8] == 24'h0)
    else $error("byte read upper lanes not zero");
endmodule

// File: dv/standby_ram_module_tb.sv
// bench for the standby ram module: cpu model, byte memory model
// assumes a 1 kilobyte array and the register layout of the package
`timescale 1ns/1ps
module standby_ram_module_tb import sram_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        standby_supply_input = 1'b0;
  logic        req, write, program_space, ack, module_stopped, base_locked, hit;
  logic        slow = 1'b1;
  logic [1:0]  size;
  logic [23:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [31:0] seed = 32'h493F;
  logic [13:0] abase = 14'h0000;
  logic [7:0]  mem [1024];
  int          failures = 0;
  int          check_count = 0;
  int          i;
  always #10 sys_clk = ~sys_clk;
  cpu_bus_model cpu (.sys_clk, .ack, .rdata, .req, .addr, .write, .size, .program_space,
    .wdata);
  standby_ram_module #(.ARRAY_KB(1)) dut (.sys_clk, .reset, .standby_supply_input, .req,
    .addr, .write, .size, .program_space, .wdata, .ack, .rdata, .module_stopped,
    .base_locked);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic acc(input logic [23:0] a, input logic w, input logic [1:0] s,
                     input logic p, input logic [31:0] d);
    cpu.access(a, w, s, p, d, slow ? int'(rnd() % 3) : 0, hit, q);
  endtask
  task automatic reg_wr(input logic [2:0] o, input logic [15:0] d);
    acc({REG_BLOCK_BASE[23:3], o}, 1'b1, SIZE_WORD, 1'b1, {16'h0000, d});
  endtask
  task automatic reg_rd(input logic [2:0] o);
    acc({REG_BLOCK_BASE[23:3], o}, 1'b0, SIZE_WORD, 1'b1, 32'h0);
  endtask
  task automatic setup(input logic [23:0] b, input logic [15:0] c);
    reg_wr(OFS_BASE_HIGH, {8'h00, b[23:16]});
    reg_wr(OFS_BASE_LOW, b[15:0]);
    reg_wr(OFS_CONFIG, c);
    abase = b[23:10];
  endtask
  // full low keeps only the first word, as a long cut short by reset
  task automatic mem_op(input logic [9:0] o, input logic w, input logic [1:0] s,
                        input logic [31:0] r, input logic full);
    logic [31:0] e, d;
    int n, k;
    n = s == SIZE_LONG ? 4 : s == SIZE_WORD ? 2 : 1;
    d = r >> (32 - 8 * n);
    e = 32'h0;
    for (k = 0; k < n; k++) e = {e[23:0], mem[int'(o) + k]};
    acc({abase, o}, w, s, 1'b1, d);
    chk("array ack", {31'h0, hit}, 32'h1);
    if (!w) chk("array data", q, e);
    for (k = 0; k < (full ? n : 2); k++) if (w) mem[int'(o) + k] = d[8 * (n - 1 - k) +: 8];
  endtask
  initial begin
    logic [31:0] rv [4];
    logic [1:0]  s;
    logic [9:0]  o;
    rv = '{{16'h0, STOP_RST, 3'h0, LOCK_RST, 9'h0, SPACE_RST}, 32'h0,
           {24'h0, BASE_HIGH_RST}, {16'h0, BASE_LOW_RST}};
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    for (i = 0; i < 4; i++) begin
      reg_rd(3'(2 * i));
      chk("reset value", q, rv[i]);
    end
    reg_wr(OFS_TEST, 16'hFFFF);
    reg_rd(OFS_TEST);
    chk("unused register", q, 32'h0);
    acc(24'h000000, 1'b0, SIZE_BYTE, 1'b1, 32'h0);
    chk("stopped array", {31'h0, hit}, 32'h0);
    setup(24'h004000, 16'h0000);
    reg_wr(OFS_BASE_LOW, 16'h8000);
    reg_rd(OFS_BASE_LOW);
    chk("base while running", q, 32'h4000);
    for (i = 0; i < 256; i++) mem_op(10'(4 * i), 1'b1, SIZE_LONG, rnd(), 1'b1);
    mem_op(10'h101, 1'b1, SIZE_WORD, rnd(), 1'b1);
    for (i = 0; i < 120; i++) begin
      s = 2'(rnd() % 3);
      o = 10'(rnd() % 1020);
      if (s == SIZE_LONG) o[0] = 1'b0;
      mem_op(o, 1'(rnd()), s, rnd(), 1'b1);
    end
    acc({abase + 14'h1, 10'h000}, 1'b0, SIZE_BYTE, 1'b1, 32'h0);
    chk("outside array", {31'h0, hit}, 32'h0);
    for (i = 0; i < 4; i++) begin
      reg_wr(OFS_CONFIG, 16'(i));
      acc({abase, 10'h000}, 1'b0, SIZE_BYTE, 1'b0, 32'h0);
      chk("data space", {31'h0, hit}, {31'h0, ~i[0]});
      acc({abase, 10'h000}, 1'b0, SIZE_BYTE, 1'b1, 32'h0);
      chk("program space", {31'h0, hit}, 32'h1);
    end
    for (i = 1; i >= 0; i--) begin
      standby_supply_input = 1'(i);
      repeat (4) @(negedge sys_clk);
      acc({abase, 10'h000}, 1'b0, SIZE_BYTE, 1'b1, 32'h0);
      chk("standby array", {31'h0, hit}, {31'h0, ~standby_supply_input});
      reg_rd(OFS_CONFIG);
      chk("standby register", {31'h0, hit}, 32'h1);
    end
    reg_wr(OFS_CONFIG, 16'h8800);
    reg_wr(OFS_BASE_LOW, 16'h0400);
    reg_wr(OFS_CONFIG, 16'h8000);
    reg_rd(OFS_BASE_LOW);
    chk("base when locked", q, 32'h4000);
    chk("lock kept", {31'h0, base_locked}, 32'h1);
    chk("stop kept", {31'h0, module_stopped}, 32'h1);
    reg_wr(OFS_CONFIG, 16'h0000);
    chk("stop cleared", {31'h0, module_stopped}, 32'h0);
    // fourth pass: a split word hit by reset still finishes both bytes
    for (i = 0; i < 4; i++) begin
      slow = 1'b0;
      fork
        mem_op(10'h200 + 10'(i == 3), 1'b1, i == 2 ? SIZE_BYTE : i == 3 ? SIZE_WORD : SIZE_LONG,
               rnd(), i != 0);
        begin
          repeat (i == 1 ? 4 : 2) @(negedge sys_clk);
          reset = 1'b1;
          repeat (6) @(negedge sys_clk);
          reset = 1'b0;
        end
      join
      slow = 1'b1;
      setup(24'h004000, 16'h0000);
      mem_op(10'h200, 1'b0, SIZE_LONG, 32'h0, 1'b1);
    end
    reg_wr(OFS_CONFIG, 16'h8000);
    setup(24'h100000, 16'h0000);
    acc(24'h100000, 1'b0, SIZE_BYTE, 1'b1, 32'h0);
    chk("unreachable base", {31'h0, hit}, 32'h0);
    reg_wr(OFS_CONFIG, 16'h8000);
    setup(24'h004000, 16'h0000);
    mem_op(10'h000, 1'b0, SIZE_LONG, 32'h0, 1'b1);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
endmodule
bind standby_ram_module sram_chk u_chk (.sys_clk, .reset, .standby_supply_input, .req, .addr,
  .write, .size, .program_space, .wdata, .ack, .rdata, .module_stopped, .base_locked);

// File: verilog/sram_array.sv
// word-wide static storage with two byte lanes, lane 1 is the even byte
// assumes writes are single-cycle strobes on sys_clk; reads are asynchronous
`timescale 1ns/1ps
module sram_array #(
  parameter int WORDS = 512
) (
  input  wire logic                     sys_clk,
  input  wire logic                     we,
  input  wire logic [1:0]               lane_en,
  input  wire logic [$clog2(WORDS)-1:0] index,
  input  wire logic [15:0]              wdata,
  output logic      [15:0]              rdata
);

  // ----------------------------------------
  // lane writes
  // ----------------------------------------
  // one store per lane, so each lane process owns its own storage
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      logic [7:0] mem [WORDS];
      always_ff @(posedge sys_clk) begin
        if (we && lane_en[lane]) begin
          mem[index] <= wdata[lane*8 +: 8];
        end
      end
      assign rdata[lane*8 +: 8] = mem[index];
    end
  endgenerate

endmodule

// File: verilog/sram_pkg.sv
// constants, field layout and bus state type of the standby ram module
// assumes a 24-bit big-endian internal bus with 16-bit data lanes
package sram_pkg;

  // ----------------------------------------
  // register block placement and offsets
  // ----------------------------------------
  localparam logic [23:0] REG_BLOCK_BASE = 24'hFFFB40;
  localparam logic [2:0]  OFS_CONFIG     = 3'h0;
  localparam logic [2:0]  OFS_TEST       = 3'h2;
  localparam logic [2:0]  OFS_BASE_HIGH  = 3'h4;
  localparam logic [2:0]  OFS_BASE_LOW   = 3'h6;

  // ----------------------------------------
  // config register fields
  // ----------------------------------------
  localparam int STOP_BIT  = 15;
  localparam int LOCK_BIT  = 11;
  localparam int SPACE_LSB = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic        STOP_RST      = 1'b1;
  localparam logic        LOCK_RST      = 1'b0;
  localparam logic [1:0]  SPACE_RST     = 2'h1;
  localparam logic [7:0]  BASE_HIGH_RST = 8'h00;
  localparam logic [15:0] BASE_LOW_RST  = 16'h0000;

  // ----------------------------------------
  // access sizes and address limits
  // ----------------------------------------
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_WORD  = 2'h1;
  localparam logic [1:0]  SIZE_LONG  = 2'h2;
  localparam logic [23:0] UNREACH_LO = 24'h080000;
  localparam logic [23:0] UNREACH_HI = 24'h7FFFFF;
  localparam int          ARRAY_KB_DEFAULT = 1;
  localparam int          BUS_CYCLE_CLKS   = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_PHASE_A, ST_PHASE_B} bus_state_t;

endpackage

// File: verilog/standby_ram_module.sv
// standby ram module: control registers, base decode and bus cycle engine
// assumes the bus master holds addr, size, write, wdata from req until ack
`timescale 1ns/1ps
module standby_ram_module
  import sram_pkg::*;
#(
  parameter int ARRAY_KB = ARRAY_KB_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        standby_supply_input,
  input  wire logic        req,
  input  wire logic [23:0] addr,
  input  wire logic        write,
  input  wire logic [1:0]  size,
  input  wire logic        program_space,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic      [31:0] rdata,
  output logic             module_stopped,
  output logic             base_locked
);

  localparam int AW    = $clog2(ARRAY_KB * 1024);
  localparam int WORDS = ARRAY_KB * 512;

  // ----------------------------------------
  // state
  // ----------------------------------------
  bus_state_t  state;
  logic        part;
  logic        reset_pending;
  logic        stby_meta;
  logic        stby_sync;
  logic [1:0]  space_type_field;
  logic [7:0]  array_base_high;
  logic [15:0] array_base_low;
  logic [23:0] a_addr;
  logic [1:0]  a_size;
  logic        a_write;
  logic        a_reg;
  logic [31:0] a_wdata;

  logic [23:0] base;
  logic        reg_hit;
  logic        array_hit;
  logic        rst_eff;
  logic        take;
  logic        two_parts;
  logic        part_byte;
  logic [23:0] part_addr;
  logic [1:0]  lane_en;
  logic [15:0] part_wdata;
  logic [15:0] part_rd;
  logic [15:0] array_rd;
  logic        strobe;
  logic        array_we;
  logic        cut_short;

  function automatic logic unreachable(input logic [23:0] b);
    return (b >= UNREACH_LO) && (b <= UNREACH_HI);
  endfunction

  function automatic logic [15:0] reg_word(input logic [2:0] ofs, input logic stop_v,
                                          input logic lock_v, input logic [1:0] spc,
                                          input logic [7:0] bh, input logic [15:0] bl);
    logic [15:0] v;
    v = 16'h0000;
    case (ofs)
      OFS_CONFIG: begin
        v[STOP_BIT] = stop_v;
        v[LOCK_BIT] = lock_v;
        v[SPACE_LSB +: 2] = spc;
      end
      OFS_BASE_HIGH: v[7:0] = bh;
      OFS_BASE_LOW:  v = bl;
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // standby supply synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    stby_meta <= standby_supply_input;
    stby_sync <= stby_meta;
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  assign base    = {array_base_high, array_base_low};
  assign reg_hit = (addr[23:3] == REG_BLOCK_BASE[23:3]);
  // registers win over an overlapping array, hiding those array bytes
  assign array_hit = (addr[23:AW] == base[23:AW])
                     && !unreachable(base)
                     && !module_stopped
                     && !stby_sync
                     && (!space_type_field[0] || program_space);
  assign rst_eff = (reset || reset_pending) && (state == ST_IDLE);
  // no match means no ack at all, another responder ends the cycle
  assign take = req && (state == ST_IDLE) && !rst_eff && (reg_hit || array_hit);

  // ----------------------------------------
  // current part of the access
  // ----------------------------------------
  assign two_parts = (a_size == SIZE_LONG) || ((a_size == SIZE_WORD) && a_addr[0]);
  assign part_byte = (a_size == SIZE_BYTE) || ((a_size == SIZE_WORD) && a_addr[0]);
  // only a long may be cut short; a split word is still one word access
  assign cut_short = (a_size == SIZE_LONG) && (reset || reset_pending);

  always_comb begin
    part_addr  = a_addr;
    part_wdata = a_wdata[15:0];
    if (a_size == SIZE_LONG) begin
      part_addr  = a_addr + {22'h000000, part, 1'b0};
      part_wdata = part ? a_wdata[15:0] : a_wdata[31:16];
    end else if (part_byte) begin
      part_addr  = a_addr + {23'h000000, part};
      part_wdata = (part || a_size == SIZE_BYTE) ? {2{a_wdata[7:0]}} : {2{a_wdata[15:8]}};
    end
  end

  assign lane_en = part_byte ? (part_addr[0] ? 2'h1 : 2'h2) : 2'h3;
  assign strobe  = (state == ST_PHASE_B);
  assign part_rd = a_reg ? reg_word(part_addr[2:0], module_stopped, base_locked,
                                    space_type_field, array_base_high, array_base_low)
                         : array_rd;
  assign array_we = strobe && a_write && !a_reg;

  sram_array #(
    .WORDS (WORDS)
  ) u_array (
    .sys_clk (sys_clk),
    .we      (array_we),
    .lane_en (lane_en),
    .index   (part_addr[AW-1:1]),
    .wdata   (part_wdata),
    .rdata   (array_rd)
  );

  // ----------------------------------------
  // bus cycle engine, two clocks per part
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst_eff) begin
      state <= ST_IDLE;
      part  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          part <= 1'b0;
          if (take) begin
            state <= ST_PHASE_A;
          end
        end
        ST_PHASE_A: state <= ST_PHASE_B;
        ST_PHASE_B: begin
          // reset seen in the first half of a long access ends it here
          if (two_parts && !part && !cut_short) begin
            part  <= 1'b1;
            state <= ST_PHASE_A;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // a reset during an access waits until the engine is idle again
  always_ff @(posedge sys_clk) begin
    if (reset && (state != ST_IDLE)) begin
      reset_pending <= 1'b1;
    end else if (state == ST_IDLE) begin
      reset_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (take) begin
      a_addr  <= addr;
      a_size  <= size;
      a_write <= write;
      a_reg   <= reg_hit;
      a_wdata <= wdata;
    end
  end

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst_eff) begin
      ack <= 1'b0;
    end else begin
      ack <= strobe && !(two_parts && !part && !cut_short);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_eff) begin
      rdata <= 32'h00000000;
    end else if (take) begin
      rdata <= 32'h00000000;
    end else if (strobe && !a_write) begin
      if (a_size == SIZE_LONG) begin
        if (part) begin
          rdata[15:0] <= part_rd;
        end else begin
          rdata[31:16] <= part_rd;
        end
      end else if (part_byte) begin
        if (part || a_size == SIZE_BYTE) begin
          rdata[7:0] <= part_addr[0] ? part_rd[7:0] : part_rd[15:8];
        end else begin
          rdata[15:8] <= part_addr[0] ? part_rd[7:0] : part_rd[15:8];
        end
      end else begin
        rdata[15:0] <= part_rd;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic reg_we;
  logic base_we;
  assign reg_we  = strobe && a_write && a_reg;
  assign base_we = reg_we && module_stopped && !base_locked;

  always_ff @(posedge sys_clk) begin
    if (rst_eff) begin
      module_stopped   <= STOP_RST;
      base_locked      <= LOCK_RST;
      space_type_field <= SPACE_RST;
    end else if (reg_we && part_addr[2:0] == OFS_CONFIG) begin
      if (lane_en[1]) begin
        module_stopped <= part_wdata[STOP_BIT];
        if (part_wdata[LOCK_BIT]) begin
          base_locked <= 1'b1;
        end
      end
      if (lane_en[0]) begin
        space_type_field <= part_wdata[SPACE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_eff) begin
      array_base_high <= BASE_HIGH_RST;
      array_base_low  <= BASE_LOW_RST;
    end else if (base_we) begin
      if (part_addr[2:0] == OFS_BASE_HIGH && lane_en[0]) begin
        array_base_high <= part_wdata[7:0];
      end
      if (part_addr[2:0] == OFS_BASE_LOW) begin
        if (lane_en[1]) begin
          array_base_low[15:8] <= part_wdata[15:8];
        end
        if (lane_en[0]) begin
          array_base_low[7:0] <= part_wdata[7:0];
        end
      end
    end
  end

endmodule
